// *** core/dmb_bank_addr.sv ***
// Bank select register, direct and full address access to data memory.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module dmb_bank_addr
  import dmb_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              req_valid,
  input  wire dmb_req_t          req,
  output logic                   req_ready,
  output dmb_rsp_t               rsp,
  output dmb_sfr_t               special_function_registers,
  input  wire logic [DATA_W-1:0] sfr_rdata,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [DATA_W-1:0] reg_rdata
);

  // ****************************************************************
  // Storage and state
  // ****************************************************************
  logic [DATA_W-1:0]    ram [0:GPR_DEPTH-1];
  logic [DATA_W-1:0]    bank_select;
  logic [DATA_W-1:0]    next_bank_select;
  dmb_state_t           state;
  dmb_state_t           next_state;
  logic [DATA_W-1:0]    move_data;
  logic [DATA_W-1:0]    next_move_data;
  logic [ADDR_W-1:0]    move_dst;
  logic [ADDR_W-1:0]    next_move_dst;
  logic                 move_src_unimpl;
  logic                 next_move_src_unimpl;
  dmb_rsp_t             next_rsp;
  logic                 last_unimpl;
  logic                 next_last_unimpl;
  logic                 last_sfr;
  logic                 next_last_sfr;
  logic [DATA_W-1:0]    next_reg_rdata;

  logic                 take;
  logic                 is_move;
  logic                 is_data_op;
  logic [ADDR_W-1:0]    a_addr;
  logic                 a_is_gpr;
  logic                 a_is_sfr;
  logic [GPR_IDX_W-1:0] a_idx;
  logic [ADDR_W-1:0]    b_addr;
  logic                 b_is_gpr;
  logic                 b_is_sfr;
  logic [GPR_IDX_W-1:0] b_idx;
  logic [DATA_W-1:0]    rd_data;
  logic                 mem_we;
  logic [GPR_IDX_W-1:0] mem_idx;
  logic [DATA_W-1:0]    mem_wd;

  // ****************************************************************
  // Request acceptance
  // ****************************************************************
  always_comb
  begin
    req_ready  = (state == DMB_ST_IDLE);
    take       = req_valid && req_ready;
    is_move    = (req.op == DMB_OP_MOVE);
    is_data_op = (req.op == DMB_OP_READ) || (req.op == DMB_OP_WRITE) || is_move;
  end

  // ****************************************************************
  // Address resolvers
  // ****************************************************************
  // Port A serves direct accesses and the source of a move.
  dmb_addr_resolve u_port_a
  (
    .full_mode  (is_move),
    .access_bit (req.access_bit),
    .bank       (bank_select[BANK_W-1:0]),
    .offset     (req.offset),
    .full_addr  (req.src),
    .addr       (a_addr),
    .is_gpr     (a_is_gpr),
    .is_sfr     (a_is_sfr),
    .gpr_idx    (a_idx)
  );

  // Port B serves the destination of a move in its second cycle.
  dmb_addr_resolve u_port_b
  (
    .full_mode  (1'b1),
    .access_bit (1'b0),
    .bank       (ACCESS_LOW_BANK),
    .offset     (ACCESS_SPLIT),
    .full_addr  (move_dst),
    .addr       (b_addr),
    .is_gpr     (b_is_gpr),
    .is_sfr     (b_is_sfr),
    .gpr_idx    (b_idx)
  );

  // ****************************************************************
  // Memory and special register port steering
  // ****************************************************************
  always_comb
  begin
    rd_data   = '0;
    mem_we    = 1'b0;
    mem_idx   = a_idx;
    mem_wd    = req.wdata;
    special_function_registers.sel   = 1'b0;
    special_function_registers.we    = 1'b0;
    special_function_registers.addr  = a_addr[SFR_W-1:0];
    special_function_registers.wdata = req.wdata;
    if (state == DMB_ST_IDLE)
    begin
      if (a_is_gpr)
      begin
        rd_data = ram[a_idx];
      end
      else if (a_is_sfr)
      begin
        rd_data = sfr_rdata;
      end
      else
      begin
        rd_data = '0;
      end
      mem_we  = take && (req.op == DMB_OP_WRITE) && a_is_gpr;
      special_function_registers.sel = take && is_data_op && a_is_sfr;
      special_function_registers.we  = take && (req.op == DMB_OP_WRITE) && a_is_sfr;
    end
    else
    begin
      mem_idx   = b_idx;
      mem_wd    = move_data;
      mem_we    = b_is_gpr;
      special_function_registers.sel   = b_is_sfr;
      special_function_registers.we    = b_is_sfr;
      special_function_registers.addr  = b_addr[SFR_W-1:0];
      special_function_registers.wdata = move_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (mem_we)
    begin
      ram[mem_idx] <= mem_wd;
    end
  end

  // ****************************************************************
  // Move sequencer
  // ****************************************************************
  always_comb
  begin
    next_state           = state;
    next_move_data       = move_data;
    next_move_dst        = move_dst;
    next_move_src_unimpl = move_src_unimpl;
    case (state)
      DMB_ST_IDLE:
      begin
        if (take && is_move)
        begin
          next_state           = DMB_ST_MOVE_WR;
          next_move_data       = rd_data;
          next_move_dst        = req.dst;
          next_move_src_unimpl = !(a_is_gpr || a_is_sfr);
        end
      end
      DMB_ST_MOVE_WR:
      begin
        next_state = DMB_ST_IDLE;
      end
      default:
      begin
        next_state = DMB_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state           <= DMB_ST_IDLE;
      move_data       <= '0;
      move_dst        <= '0;
      move_src_unimpl <= 1'b0;
    end
    else
    begin
      state           <= next_state;
      move_data       <= next_move_data;
      move_dst        <= next_move_dst;
      move_src_unimpl <= next_move_src_unimpl;
    end
  end

  // ****************************************************************
  // Bank select register
  // ****************************************************************
  // The bank load instruction wins over a software write in the same cycle.
  always_comb
  begin
    next_bank_select = bank_select;
    if (take && (req.op == DMB_OP_BANK_LOAD))
    begin
      next_bank_select = req.wdata & BANK_NIBBLE_MASK;
    end
    else if (reg_write && (reg_addr == REG_BANK_SELECT))
    begin
      next_bank_select = reg_wdata & BANK_NIBBLE_MASK;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      bank_select <= BANK_SELECT_RESET;
    end
    else
    begin
      bank_select <= next_bank_select;
    end
  end

  // ****************************************************************
  // Response to the core
  // ****************************************************************
  // The zero flag is formed from the returned byte whatever the bank holds.
  always_comb
  begin
    next_rsp = '0;
    if ((state == DMB_ST_IDLE) && take && !is_move)
    begin
      next_rsp.done = (req.op != DMB_OP_NONE);
      next_rsp.addr = a_addr;
      case (req.op)
        DMB_OP_READ:
        begin
          next_rsp.rdata  = rd_data;
          next_rsp.zero   = (rd_data == '0);
          next_rsp.unimpl = !(a_is_gpr || a_is_sfr);
        end
        DMB_OP_WRITE:
        begin
          next_rsp.rdata  = req.wdata;
          next_rsp.zero   = (req.wdata == '0);
          next_rsp.unimpl = !(a_is_gpr || a_is_sfr);
        end
        DMB_OP_BANK_LOAD:
        begin
          next_rsp.rdata = req.wdata & BANK_NIBBLE_MASK;
          next_rsp.zero  = ((req.wdata & BANK_NIBBLE_MASK) == '0);
        end
        default:
        begin
          next_rsp.rdata = '0;
        end
      endcase
    end
    else if (state == DMB_ST_MOVE_WR)
    begin
      next_rsp.done   = 1'b1;
      next_rsp.addr   = b_addr;
      next_rsp.rdata  = move_data;
      next_rsp.zero   = (move_data == '0);
      next_rsp.unimpl = move_src_unimpl || !(b_is_gpr || b_is_sfr);
    end
  end

  always_comb
  begin
    next_last_unimpl = last_unimpl;
    next_last_sfr    = last_sfr;
    if (next_rsp.done && (req.op != DMB_OP_BANK_LOAD || state == DMB_ST_MOVE_WR))
    begin
      next_last_unimpl = next_rsp.unimpl;
      next_last_sfr    = (state == DMB_ST_MOVE_WR) ? b_is_sfr : a_is_sfr;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rsp         <= '0;
      last_unimpl <= 1'b0;
      last_sfr    <= 1'b0;
    end
    else
    begin
      rsp         <= next_rsp;
      last_unimpl <= next_last_unimpl;
      last_sfr    <= next_last_sfr;
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  always_comb
  begin
    next_reg_rdata = '0;
    if (reg_read)
    begin
      case (reg_addr)
        REG_BANK_SELECT:
        begin
          next_reg_rdata = bank_select & BANK_NIBBLE_MASK;
        end
        REG_ACCESS_STATUS:
        begin
          next_reg_rdata[STAT_UNIMPL_BIT] = last_unimpl;
          next_reg_rdata[STAT_BUSY_BIT]   = (state == DMB_ST_MOVE_WR);
          next_reg_rdata[STAT_SFR_BIT]    = last_sfr;
        end
        default:
        begin
          next_reg_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      reg_rdata <= '0;
    end
    else
    begin
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule

// *** pkg/dmb_pkg.sv ***
// Constants, encodings and carrier types of the data memory bank addressing block.
package dmb_pkg;

  // ****************************************************************
  // Widths and memory layout
  // ****************************************************************
  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 12;
  localparam int OFS_W     = 8;
  localparam int BANK_W    = 4;
  localparam int SFR_W     = 7;
  localparam int BANK_SIZE = 256;
  localparam int GPR_BANKS = 6;
  localparam int GPR_DEPTH = GPR_BANKS * BANK_SIZE;
  localparam int GPR_IDX_W = 11;

  localparam logic [OFS_W-1:0]  ACCESS_SPLIT     = 8'h80;
  localparam logic [BANK_W-1:0] ACCESS_LOW_BANK  = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [BANK_W-1:0] GPR_BANK_LIMIT   = 4'h6;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] REG_BANK_SELECT   = 8'h00;
  localparam logic [7:0] REG_ACCESS_STATUS = 8'h01;

  localparam logic [DATA_W-1:0] BANK_SELECT_RESET = 8'h00;
  localparam logic [DATA_W-1:0] BANK_NIBBLE_MASK  = 8'h0F;

  localparam int STAT_UNIMPL_BIT = 0;
  localparam int STAT_BUSY_BIT   = 1;
  localparam int STAT_SFR_BIT    = 2;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  typedef enum logic [2:0]
  {
    DMB_OP_NONE      = 3'b000,
    DMB_OP_READ      = 3'b001,
    DMB_OP_WRITE     = 3'b010,
    DMB_OP_MOVE      = 3'b011,
    DMB_OP_BANK_LOAD = 3'b100
  } dmb_op_t;

  typedef enum logic
  {
    DMB_ST_IDLE    = 1'b0,
    DMB_ST_MOVE_WR = 1'b1
  } dmb_state_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed
  {
    dmb_op_t           op;
    logic              access_bit;
    logic [OFS_W-1:0]  offset;
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
    logic [DATA_W-1:0] wdata;
  } dmb_req_t;

  typedef struct packed
  {
    logic              done;
    logic [DATA_W-1:0] rdata;
    logic              zero;
    logic              unimpl;
    logic [ADDR_W-1:0] addr;
  } dmb_rsp_t;

  typedef struct packed
  {
    logic              sel;
    logic              we;
    logic [SFR_W-1:0]  addr;
    logic [DATA_W-1:0] wdata;
  } dmb_sfr_t;

endpackage

// *** core/dmb_addr_resolve.sv ***
// Effective address resolver for one data memory port.
`timescale 1ns/1ns
module dmb_addr_resolve
  import dmb_pkg::*;
(
  input  wire logic                 full_mode,
  input  wire logic                 access_bit,
  input  wire logic [BANK_W-1:0]    bank,
  input  wire logic [OFS_W-1:0]     offset,
  input  wire logic [ADDR_W-1:0]    full_addr,
  output logic      [ADDR_W-1:0]    addr,
  output logic                      is_gpr,
  output logic                      is_sfr,
  output logic      [GPR_IDX_W-1:0] gpr_idx
);

  // ****************************************************************
  // Address formation
  // ****************************************************************
  always_comb
  begin
    if (full_mode)
    begin
      addr = full_addr;
    end
    else if (!access_bit)
    begin
      if (offset < ACCESS_SPLIT)
      begin
        addr = {ACCESS_LOW_BANK, offset};
      end
      else
      begin
        addr = {ACCESS_HIGH_BANK, offset};
      end
    end
    else
    begin
      addr = {bank, offset};
    end
  end

  // ****************************************************************
  // Decode of what stands behind the address
  // ****************************************************************
  always_comb
  begin
    is_gpr  = (addr[ADDR_W-1 -: BANK_W] < GPR_BANK_LIMIT);
    is_sfr  = (addr[ADDR_W-1 -: BANK_W] == ACCESS_HIGH_BANK) && addr[OFS_W-1];
    gpr_idx = addr[GPR_IDX_W-1:0];
  end

endmodule

// *** tb/dmb_bank_addr_monitor.sv ***
// Concurrent checks on the ports of the bank addressing block.
`timescale 1ns/1ns
module dmb_bank_addr_monitor
  import dmb_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              req_valid,
  input wire dmb_req_t          req,
  input wire logic              req_ready,
  input wire dmb_rsp_t          rsp,
  input wire dmb_sfr_t          special_function_registers,
  input wire logic [DATA_W-1:0] sfr_rdata,
  input wire logic [7:0]        reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_write,
  input wire logic              reg_read,
  input wire logic [DATA_W-1:0] reg_rdata
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic              tk;
  logic              rw;
  logic              bad;
  logic [BANK_W-1:0] bk;
  logic [BANK_W-1:0] next_bk;
  logic [ADDR_W-1:0] ea;
  // ****************************************************************
  // Shadow of the bank nibble and the effective address
  // ****************************************************************
  assign tk  = req_valid && req_ready;
  assign rw  = req.op == DMB_OP_READ || req.op == DMB_OP_WRITE;
  assign ea  = req.access_bit ? {bk, req.offset} :
               {req.offset < ACCESS_SPLIT ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, req.offset};
  assign bad = ea >= 12'h600 && ea < 12'hF80;
  always_comb
  begin
    next_bk = bk;
    if (reg_write && reg_addr == REG_BANK_SELECT)
      next_bk = reg_wdata[3:0];
    if (tk && req.op == DMB_OP_BANK_LOAD)
      next_bk = req.wdata[3:0];
  end
  always_ff @(posedge clock)
    bk <= rst ? 4'h0 : next_bk;
  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_BANK_HI:
    assert property (reg_read && reg_addr == REG_BANK_SELECT |=> reg_rdata[7:4] == 4'h0)
    else $error("Bank select upper nibble read nonzero.");
  AST_BANK_LOAD:
    assert property (tk && req.op == DMB_OP_BANK_LOAD |=>
      rsp.done && rsp.rdata == ($past(req.wdata) & 8'h0F))
    else $error("Bank load gave wrong value.");
  AST_EA:
    assert property (tk && rw |=> rsp.done && rsp.addr == $past(ea))
    else $error("Effective address wrong.");
  AST_SPECIAL:
    assert property (tk && rw && ea[11:7] == 5'h1F |->
      special_function_registers.sel && special_function_registers.addr == req.offset[6:0] && special_function_registers.we == (req.op == DMB_OP_WRITE))
    else $error("Special register access not issued.");
  AST_UNIMPL_RD:
    assert property (tk && req.op == DMB_OP_READ && bad |=>
      rsp.unimpl && rsp.rdata == 8'h00)
    else $error("Unimplemented read not zero.");
  AST_UNIMPL_WR:
    assert property (tk && req.op == DMB_OP_WRITE && bad |-> !special_function_registers.we)
    else $error("Unimplemented write reached a register.");
  AST_ZERO:
    assert property (rsp.done && rsp.unimpl && rsp.rdata == 8'h00 |-> rsp.zero)
    else $error("Zero flag missing on unimplemented access.");
  AST_MOVE:
    assert property (tk && req.op == DMB_OP_MOVE |=>
      !req_ready ##1 rsp.done && rsp.addr == $past(req.dst, 2))
    else $error("Full address move wrong.");
endmodule

// *** tb/dmb_special_model.sv ***
// Special register file model on the far side of the special register port.
`timescale 1ns/1ns
module dmb_special_model
  import dmb_pkg::*;
(
  input  wire logic              clock,
  input  wire dmb_sfr_t          special_function_registers,
  output logic      [DATA_W-1:0] sfr_rdata
);
  logic [DATA_W-1:0] mem [128];
  initial
  begin
    for (int i = 0; i < 128; i++)
      mem[i] = 8'h00;
  end
  // Unselected reads show the inverse so a stale byte never passes as data.
  assign sfr_rdata = special_function_registers.sel ? mem[special_function_registers.addr] : ~mem[special_function_registers.addr];
  always @(posedge clock)
    if (special_function_registers.sel && special_function_registers.we)
      mem[special_function_registers.addr] <= special_function_registers.wdata;
endmodule

// *** tb/dmb_bank_addr_tb.sv ***
// Self-checking testbench of the bank addressing block.
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR %0t got %h expected %h", $time, (a), (e)); end end
module dmb_bank_addr_tb;
  import dmb_pkg::*;
  logic              clock     = 1'b0;
  logic              rst       = 1'b1;
  logic              req_valid = 1'b0;
  dmb_req_t          req       = '0;
  logic              req_ready;
  dmb_rsp_t          rsp;
  dmb_sfr_t          special_function_registers;
  logic [DATA_W-1:0] sfr_rdata;
  logic [7:0]        reg_addr  = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic              reg_write = 1'b0;
  logic              reg_read  = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [7:0]        sh [4096];
  logic [3:0]        bsel      = 4'h0;
  int                bad_count = 0;
  int                n_tests   = 0;
  dmb_bank_addr dmb_bank_addr_i (.clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp(rsp), .special_function_registers(special_function_registers), .sfr_rdata(sfr_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
  dmb_special_model dmb_special_model_i (.clock(clock), .special_function_registers(special_function_registers), .sfr_rdata(sfr_rdata));
  initial
  begin
    forever #50 clock = ~clock;
  end
  // ****************************************************************
  // Expectation functions and bus tasks
  // ****************************************************************
  function automatic logic [11:0] ea(logic ab, logic [3:0] b, logic [7:0] o);
    if (ab)
      return {b, o};
    return {(o < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, o};
  endfunction
  function automatic logic impl(logic [11:0] a);
    return a < 12'h600 || a >= 12'hF80;
  endfunction
  function automatic logic [7:0] rexp(logic [11:0] a);
    return impl(a) ? sh[a] : 8'h00;
  endfunction
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rw(logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rr(logic [7:0] a, logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    `CHK(reg_rdata, e)
  endtask
  task automatic dop(dmb_op_t o, logic ab, logic [7:0] f, logic [11:0] s, logic [11:0] d,
                     logic [7:0] wd);
    logic [11:0] a;
    logic [7:0]  v;
    logic        u;
    a = (o == DMB_OP_MOVE) ? d : ea(ab, bsel, f);
    v = (o == DMB_OP_WRITE) ? wd : rexp((o == DMB_OP_MOVE) ? s : a);
    u = !impl(a) || (o == DMB_OP_MOVE && !impl(s));
    @(posedge clock);
    req_valid <= 1'b1;
    req       <= '{op: o, access_bit: ab, offset: f, src: s, dst: d, wdata: wd};
    @(posedge clock);
    req_valid <= 1'b0;
    if (o == DMB_OP_MOVE)
      @(posedge clock);
    @(negedge clock);
    `CHK(rsp.done, 1'b1)
    if (o == DMB_OP_BANK_LOAD)
    begin
      bsel = wd[3:0];
      `CHK(rsp.rdata, {4'h0, wd[3:0]})
    end
    else
    begin
      `CHK(rsp.addr, a)
      `CHK(rsp.rdata, v)
      `CHK(rsp.unimpl, u)
      `CHK(rsp.zero, v == 8'h00)
      if (o != DMB_OP_READ && impl(a))
        sh[a] = v;
    end
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    logic [7:0] corner [4];
    corner = '{8'h7F, 8'h80, 8'hFF, 8'h00};
    for (int i = 0; i < 4096; i++)
      sh[i] = 8'h00;
    void'($urandom(32'h37FB));
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rr(REG_BANK_SELECT, BANK_SELECT_RESET);
    rw(REG_BANK_SELECT, 8'hA5);
    bsel = 4'h5;
    rr(REG_BANK_SELECT, 8'h05);
    rw(8'h7E, 8'hFF);
    rr(8'h7E, 8'h00);
    for (int b = 0; b < 16; b++)
    begin
      dop(DMB_OP_BANK_LOAD, 1'b0, 8'h00, 12'h000, 12'h000, 8'hF0 | 8'(b));
      for (int o = 0; o < 256; o++)
        dop(DMB_OP_WRITE, 1'b1, 8'(o), 12'h000, 12'h000, 8'($urandom));
    end
    for (int i = 0; i < 4; i++)
    begin
      dop(DMB_OP_WRITE, 1'b0, corner[i], 12'h000, 12'h000, 8'($urandom));
      dop(DMB_OP_READ, 1'b0, corner[i], 12'h000, 12'h000, 8'h00);
    end
    fork
      rw(REG_BANK_SELECT, 8'h09);
      dop(DMB_OP_BANK_LOAD, 1'b0, 8'h00, 12'h000, 12'h000, 8'h02);
    join
    rr(REG_BANK_SELECT, 8'h02);
    dop(DMB_OP_MOVE, 1'b0, 8'h00, 12'h700, 12'h010, 8'h00);
    rr(REG_ACCESS_STATUS, 8'h01);
    // The status read lands in the dead cycle of the move, so busy shows.
    fork
      dop(DMB_OP_MOVE, 1'b0, 8'h00, 12'h210, 12'hF85, 8'h00);
      begin
        @(posedge clock);
        rr(REG_ACCESS_STATUS, 8'h03);
      end
    join
    dop(DMB_OP_READ, 1'b0, 8'h85, 12'h000, 12'h000, 8'h00);
    rr(REG_ACCESS_STATUS, 8'h04);
    // An empty request is taken but gives no response and leaves the status alone.
    @(posedge clock);
    req_valid <= 1'b1;
    req.op    <= DMB_OP_NONE;
    @(posedge clock);
    req_valid <= 1'b0;
    @(negedge clock);
    `CHK(rsp.done, 1'b0)
    rr(REG_ACCESS_STATUS, 8'h04);
    for (int i = 0; i < 400; i++)
      dop(dmb_op_t'($urandom_range(4, 1)), 1'($urandom), 8'($urandom), 12'($urandom),
          12'($urandom), 8'($urandom));
    rr(REG_BANK_SELECT, {4'h0, bsel});
    // A second reset in mid-run returns the bank select and the status to zero.
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    bsel = 4'h0;
    rr(REG_BANK_SELECT, BANK_SELECT_RESET);
    rr(REG_ACCESS_STATUS, 8'h00);
    dop(DMB_OP_READ, 1'b1, 8'h10, 12'h000, 12'h000, 8'h00);
    summarize();
  end
  initial
  begin
    repeat (40000) @(posedge clock);
    bad_count++;
    summarize();
  end
endmodule
bind dmb_bank_addr dmb_bank_addr_monitor dmb_bank_addr_monitor_i (.clock(clock), .rst(rst),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp(rsp), .special_function_registers(special_function_registers),
  .sfr_rdata(sfr_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata));
